// File: inc/bit_i2c_pkg.sv
/*
 * package for the bit-level two-wire serial interface: register offsets,
 * field positions, reset values, timing counts and the packed carriers.
 * assumes nothing of its surroundings; only the interface module refers to it by scope, the line filter does not.
 */
package bit_i2c_pkg;

    // ----------------------------------------------------------------
    // register map (byte offsets on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_INT_CTRL = 4'h0;   // serial_int_ctrl_reg
    localparam logic [3:0] OFS_BIT_DATA = 4'h1;   // single_bit_data_reg
    localparam logic [3:0] OFS_CTRL_STS = 4'h2;   // serial_ctrl_status_reg
    localparam logic [3:0] OFS_IRQ_STS  = 4'h3;   // sticky event status, read only
    localparam logic [3:0] OFS_IRQ_CLR  = 4'h4;   // write one to clear, write only
    localparam logic [3:0] OFS_IRQ_EN   = 4'h5;   // event enable

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    // control/status register
    localparam int CS_MASTER = 0;                  // master mode, rw
    localparam int CS_SCL_HI = 1;                  // software scl release, rw
    localparam int CS_RESUME = 2;                  // write 1: resume next bit
    localparam int CS_CLH    = 3;                  // clock_rise_seen, ro
    localparam int CS_RBF    = 4;                  // read_bit_finished, ro
    localparam int CS_WBF    = 5;                  // write_bit_finished, ro
    localparam int CS_BB     = 6;                  // bus_busy_flag, ro
    localparam int CS_HOLD   = 7;                  // scl held low by hardware, ro
    // single-bit data register
    localparam int BD_TX     = 0;                  // tx_bit_out, rw
    localparam int BD_RX     = 1;                  // rx_bit_in, ro
    // interrupt control register
    localparam int IC_SI     = 0;                  // serial interrupt request, w1 clears
    // event bits of the status/clear/enable registers
    localparam int EV_START  = 0;
    localparam int EV_STOP   = 1;
    localparam int EV_BIT    = 2;
    localparam int EV_ARB    = 3;
    localparam int EV_W      = 4;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CTRL  = 8'h02;       // slave, scl released
    localparam int CLK_MHZ           = 125;         // system clock rate
    localparam int FILT_NS           = 48;          // glitch filter time
    localparam int FILT_CYC          = (FILT_NS * CLK_MHZ + 999) / 1000;
    localparam int HALF_NS           = 5000;        // automatic scl half period
    localparam int HALF_CYC          = (HALF_NS * CLK_MHZ) / 1000;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;                           // register offset
        logic [7:0] wdata;                          // write data
        logic       wr;                             // write strobe
        logic       rd;                             // read strobe
    } reg_req_type;

    typedef struct packed {
        logic scl;                                  // filtered scl level
        logic sda;                                  // filtered sda level
    } line_type;

endpackage : bit_i2c_pkg

// File: logic/line_filter.sv
/*
 * two-stage synchroniser plus a stability filter for one bus line.
 * assumes an asynchronous pin input; output changes only after the
 * synchronised level has stood for a full filter time.
 */
`timescale 1ns/1ps
module line_filter #(
    parameter int CYC = 6                           // cycles of stability required
) (
    input  wire logic clk_i,                        // system clock
    input  wire logic rst_i,                        // sync reset, high
    input  wire logic pin_i,                        // raw pin level
    output logic      lvl_o                         // filtered level
);
    initial begin
        if (CYC < 1 || CYC > 255) $error("line_filter: CYC out of range");
    end

    typedef struct packed {
        logic       s1;                             // first sync stage
        logic       s2;                             // second sync stage
        logic [7:0] cnt;                            // stability counter
        logic       lvl;                            // accepted level
    } st_type;

    st_type st_r;                                   // state
    st_type st_nxt;                                 // next state

    // ----------------------------------------------------------------
    // filter
    // ----------------------------------------------------------------
    // idle bus is high, so reset to high to avoid a false start
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.lvl) begin
            st_nxt.cnt = 8'h00;                     // agrees: nothing pending
        end else if (st_r.cnt == 8'(CYC - 1)) begin
            st_nxt.lvl = st_r.s2;                   // stood long enough
            st_nxt.cnt = 8'h00;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, lvl: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_o = st_r.lvl;

endmodule : line_filter

// File: logic/bit_i2c.sv
/*
 * bit-level two-wire serial interface: filters the lines, finds start,
 * stop and clock edges, latches bits, stretches scl between bits and
 * generates scl pulses in master mode. software does bytes and acks.
 * assumes a plain register port on clk_i and open-drain pads outside.
 */
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module bit_i2c #(
    parameter int FILT = bit_i2c_pkg::FILT_CYC,     // filter cycles
    parameter int HALF = bit_i2c_pkg::HALF_CYC      // automatic scl half period
) (
    input  wire logic       clk_i,                  // 125 MHz clock
    input  wire logic       rst_i,                  // sync reset, high
    input  wire logic [3:0] addr_i,                 // register offset
    input  wire logic [7:0] wdata_i,                // write data
    input  wire logic       wr_i,                   // write strobe
    input  wire logic       rd_i,                   // read strobe
    output logic      [7:0] rdata_o,                // read data, cycle after rd
    output logic            irq_o,                  // level interrupt
    input  wire logic       scl_i,                  // scl pin level
    output logic            scl_o,                  // scl output value (0)
    output logic            scl_oe_n_o,             // low while pulling scl low
    input  wire logic       sda_i,                  // sda pin level
    output logic            sda_o,                  // sda output value (0)
    output logic            sda_oe_n_o              // low while pulling sda low
);
    initial begin
        if (HALF < 2 || HALF > 65535) $error("bit_i2c: HALF out of range");
        if (FILT < 1 || FILT > 255) $error("bit_i2c: FILT out of range");
    end

    localparam int EW = bit_i2c_pkg::EV_W;

    typedef struct packed {
        bit_i2c_pkg::line_type prev;                // last filtered levels
        logic          master;                      // master mode
        logic          scl_sw;                      // software scl release
        logic          clock_rise_seen;                         // clock_rise_seen
        logic          read_bit_finished;                         // read_bit_finished
        logic          write_bit_finished;                         // write_bit_finished
        logic          bb;                          // bus_busy_flag
        logic          hold;                        // stretching scl
        logic          arb;                         // arbitration lost this bit
        logic          tx;                          // tx_bit_out
        logic          rx;                          // rx_bit_in
        logic          si;                          // serial interrupt request
        logic          start_armed;                 // start seen, awaiting fall
        logic          auto_run;                    // automatic pulse running
        logic          auto_hi;                     // automatic pulse high phase
        logic [15:0]   tmr;                         // half-period timer
        logic [EW-1:0] ev;                          // sticky events
        logic [EW-1:0] en;                          // event enables
        logic [7:0]    rdata;                       // read data register
    } st_type;

    st_type                st_r;                    // state
    st_type                st_nxt;                  // next state
    bit_i2c_pkg::line_type ln;                      // filtered lines
    bit_i2c_pkg::reg_req_type req;                  // register request
    logic                  scl_rise;                // filtered scl edges
    logic                  scl_fall;
    logic                  start_det;               // start condition
    logic                  stop_det;                // stop condition
    logic                  drive_scl_low;           // own scl pull-down
    logic                  drive_sda_low;           // own sda pull-down

    // ----------------------------------------------------------------
    // line filters
    // ----------------------------------------------------------------
    // nothing below looks at the raw pins, only at the filtered levels
    line_filter #(.CYC(FILT)) u_scl_filt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (scl_i),
        .lvl_o (ln.scl)
    );
    line_filter #(.CYC(FILT)) u_sda_filt (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (sda_i),
        .lvl_o (ln.sda)
    );

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ----------------------------------------------------------------
    // condition and edge detection
    // ----------------------------------------------------------------
    assign scl_rise  = ln.scl & ~st_r.prev.scl;
    assign scl_fall  = ~ln.scl & st_r.prev.scl;
    assign start_det = st_r.prev.scl & ln.scl & st_r.prev.sda & ~ln.sda;
    assign stop_det  = st_r.prev.scl & ln.scl & ~st_r.prev.sda & ln.sda;

    // ----------------------------------------------------------------
    // main next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic [EW-1:0] ev_set;                      // events this cycle
        logic          resume;                      // software resumes
        logic          bit_wr;                      // write of bit register
        ev_set = '0;
        resume = 1'b0;
        bit_wr = 1'b0;
        st_nxt = st_r;
        st_nxt.prev = ln;

        // register writes
        if (req.wr) begin
            unique case (req.addr)
                bit_i2c_pkg::OFS_INT_CTRL: begin
                    if (req.wdata[bit_i2c_pkg::IC_SI]) st_nxt.si = 1'b0;
                end
                bit_i2c_pkg::OFS_BIT_DATA: begin
                    st_nxt.tx = req.wdata[bit_i2c_pkg::BD_TX];
                    bit_wr    = 1'b1;               // also resumes the bit
                end
                bit_i2c_pkg::OFS_CTRL_STS: begin
                    st_nxt.master = req.wdata[bit_i2c_pkg::CS_MASTER];
                    st_nxt.scl_sw = req.wdata[bit_i2c_pkg::CS_SCL_HI];
                    resume        = req.wdata[bit_i2c_pkg::CS_RESUME];
                end
                bit_i2c_pkg::OFS_IRQ_CLR: st_nxt.ev = st_r.ev & ~req.wdata[EW-1:0];
                bit_i2c_pkg::OFS_IRQ_EN:  st_nxt.en = req.wdata[EW-1:0];
                default: ;                          // unmapped writes ignored
            endcase
        end

        // resume: release scl and clear the three flags at once
        if (resume || bit_wr) begin
            st_nxt.hold = 1'b0;
            st_nxt.clock_rise_seen  = 1'b0;
            st_nxt.read_bit_finished  = 1'b0;
            st_nxt.write_bit_finished  = 1'b0;
            st_nxt.arb  = 1'b0;
        end
        // in master mode a bit register write starts an automatic pulse
        if (bit_wr && st_r.master && !st_r.auto_run) begin
            st_nxt.auto_run = 1'b1;
            st_nxt.auto_hi  = 1'b0;
            st_nxt.tmr      = 16'(HALF - 1);
        end

        // automatic clock: low half for data setup, then high half
        if (st_r.auto_run) begin
            if (st_r.tmr != 16'h0000) begin
                if (!(st_r.auto_hi && !ln.scl)) st_nxt.tmr = st_r.tmr - 16'h0001;
            end else if (!st_r.auto_hi) begin
                st_nxt.auto_hi = 1'b1;
                st_nxt.tmr     = 16'(HALF - 1);
            end else begin
                st_nxt.auto_run = 1'b0;
                st_nxt.auto_hi  = 1'b0;
            end
        end

        // bit sampling on scl rise; arbitration check on the same edge
        if (scl_rise) begin
            st_nxt.clock_rise_seen = 1'b1;
            st_nxt.rx  = ln.sda;
            if (st_r.tx && !ln.sda) st_nxt.arb = 1'b1;
        end
        // pulse complete on scl fall: finished flags and stretch
        if (scl_fall && !st_r.start_armed) begin
            st_nxt.read_bit_finished  = 1'b1;
            st_nxt.write_bit_finished  = ~(st_r.arb | (st_r.tx & ~st_r.prev.sda));
            st_nxt.hold = 1'b1;
            ev_set[bit_i2c_pkg::EV_BIT] = 1'b1;
            if (st_nxt.arb || (st_r.tx && !st_r.prev.sda)) ev_set[bit_i2c_pkg::EV_ARB] = 1'b1;
        end

        // start: set busy, wait for first scl fall to interrupt
        if (start_det) begin
            st_nxt.bb          = 1'b1;
            st_nxt.start_armed = 1'b1;
            ev_set[bit_i2c_pkg::EV_START] = 1'b1;
        end else if (scl_fall && st_r.start_armed) begin
            st_nxt.start_armed = 1'b0;
            st_nxt.si          = 1'b1;
            st_nxt.hold        = 1'b1;
        end
        if (stop_det) begin
            st_nxt.bb          = 1'b0;
            st_nxt.start_armed = 1'b0;
            ev_set[bit_i2c_pkg::EV_STOP] = 1'b1;
        end

        // sticky events: a set in the clear cycle wins
        st_nxt.ev = st_nxt.ev | ev_set;

        // read data, valid the cycle after the strobe
        st_nxt.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                bit_i2c_pkg::OFS_INT_CTRL: st_nxt.rdata[bit_i2c_pkg::IC_SI] = st_r.si;
                bit_i2c_pkg::OFS_BIT_DATA: begin
                    st_nxt.rdata[bit_i2c_pkg::BD_TX] = st_r.tx;
                    st_nxt.rdata[bit_i2c_pkg::BD_RX] = st_r.rx;
                end
                bit_i2c_pkg::OFS_CTRL_STS: begin
                    st_nxt.rdata[bit_i2c_pkg::CS_MASTER] = st_r.master;
                    st_nxt.rdata[bit_i2c_pkg::CS_SCL_HI] = st_r.scl_sw;
                    st_nxt.rdata[bit_i2c_pkg::CS_CLH]    = st_r.clock_rise_seen;
                    st_nxt.rdata[bit_i2c_pkg::CS_RBF]    = st_r.read_bit_finished;
                    st_nxt.rdata[bit_i2c_pkg::CS_WBF]    = st_r.write_bit_finished;
                    st_nxt.rdata[bit_i2c_pkg::CS_BB]     = st_r.bb;
                    st_nxt.rdata[bit_i2c_pkg::CS_HOLD]   = st_r.hold;
                end
                bit_i2c_pkg::OFS_IRQ_STS: st_nxt.rdata[EW-1:0] = st_r.ev;
                bit_i2c_pkg::OFS_IRQ_EN:  st_nxt.rdata[EW-1:0] = st_r.en;
                default: ;                          // unmapped reads zero
            endcase
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r        <= '0;
            st_r.prev   <= '{scl: 1'b1, sda: 1'b1};
            st_r.master <= bit_i2c_pkg::RST_CTRL[bit_i2c_pkg::CS_MASTER];
            st_r.scl_sw <= bit_i2c_pkg::RST_CTRL[bit_i2c_pkg::CS_SCL_HI];
            st_r.tx     <= 1'b1;                    // released after reset
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    // stretching overrides everything; a master without a running pulse
    // follows the software scl bit, which is how manual clocking works
    assign drive_scl_low = st_r.hold
                         | (st_r.auto_run & ~st_r.auto_hi)
                         | (~st_r.auto_run & ~st_r.scl_sw);
    // data changes only while scl is low so it never fakes a start or stop;
    // a line already pulled low stays pulled through the scl rise, so the
    // filter lag on scl can never open a one-cycle stop on the wire
    assign drive_sda_low = ~st_r.tx & (~ln.scl | ~st_r.prev.sda);
    assign scl_o      = 1'b0;
    assign sda_o      = 1'b0;
    assign scl_oe_n_o = ~drive_scl_low;
    assign sda_oe_n_o = ~drive_sda_low;
    assign rdata_o    = st_r.rdata;
    assign irq_o      = st_r.si | (|(st_r.ev & st_r.en));

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_STOP_CLEARS_BB: assert property (@(posedge clk_i) disable iff (rst_i)
        stop_det |=> !st_r.bb) else $error("busy not cleared by stop");
    AST_START_SETS_BB: assert property (@(posedge clk_i) disable iff (rst_i)
        start_det && !stop_det |=> st_r.bb) else $error("busy not set");
    AST_RISE_CLH: assert property (@(posedge clk_i) disable iff (rst_i)
        scl_rise |=> st_r.clock_rise_seen && st_r.rx == $past(ln.sda)) else $error("rise not captured");
    AST_FALL_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        scl_fall && !st_r.start_armed && !(wr_i) |=> st_r.read_bit_finished && st_r.hold && !scl_oe_n_o)
        else $error("no stretch after bit");
    AST_ARB_NO_WBF: assert property (@(posedge clk_i) disable iff (rst_i)
        scl_fall && !st_r.start_armed && st_r.arb |=> !st_r.write_bit_finished) else $error("wbf despite loss");
    AST_START_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
        scl_fall && st_r.start_armed && !start_det |=> st_r.si && irq_o) else $error("no start irq");
    AST_RESUME: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i && addr_i == bit_i2c_pkg::OFS_CTRL_STS && wdata_i[bit_i2c_pkg::CS_RESUME] && !scl_rise
        && !scl_fall |=> !st_r.hold && !st_r.clock_rise_seen && !st_r.read_bit_finished && !st_r.write_bit_finished) else $error("resume");
    // each assertion guards one rule; a stretch may legally keep scl low
    AST_AUTO_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_r.auto_hi) && !st_r.hold |-> scl_oe_n_o) else $error("auto pulse");
    AST_AUTO_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i && addr_i == bit_i2c_pkg::OFS_BIT_DATA && st_r.master && !st_r.auto_run
        |=> st_r.auto_run && !scl_oe_n_o) else $error("auto pulse not started");
    AST_SDA_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
        ln.scl && sda_oe_n_o |=> sda_oe_n_o || !ln.scl || !st_r.prev.sda) else $error("sda moved");
    AST_FILT_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(ln.scl) |=> $stable(ln.scl)) else $error("filter glitch passed");
    COV_START: cover property (@(posedge clk_i) start_det);
    COV_STOP: cover property (@(posedge clk_i) stop_det);
    COV_AUTO: cover property (@(posedge clk_i) $fell(st_r.auto_run));
    COV_ARB: cover property (@(posedge clk_i) st_r.arb);
    COV_RESUME: cover property (@(posedge clk_i) st_r.hold ##1 !st_r.hold);

endmodule : bit_i2c

// File: tb/bus_partner.sv
/*
 * far side of the two-wire bus: another master or slave that may pull
 * either line low. assumes pull-ups on both lines and open-drain pads.
 */
`timescale 1ns/1ps
module bus_partner (
    input  wire logic scl_oe_n_i, // device scl enable, low pulls
    input  wire logic sda_oe_n_i, // device sda enable, low pulls
    input  wire logic pull_scl_i, // partner pulls scl low
    input  wire logic pull_sda_i, // partner pulls sda low
    output logic      scl_o,      // resolved scl wire
    output logic      sda_o       // resolved sda wire
);
    // ----------------------------------------------------------------
    // wired-and with pull-ups: a released line reads high, never stale
    // ----------------------------------------------------------------
    assign scl_o = scl_oe_n_i & ~pull_scl_i;
    assign sda_o = sda_oe_n_i & ~pull_sda_i;
endmodule : bus_partner

// File: tb/tb_top.sv
/*
 * self-checking bench for the bit-level two-wire interface.
 * assumes the partner model resolves both lines; filter and half period shortened.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, irq_o, scl, sda, scl_oe_n, sda_oe_n, scl_lo, sda_lo;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, v;
    logic pull_scl = 0, pull_sda = 0; // partner pulls, idle released
    int miscompares = 0, total_checks = 0;
    logic [11:0] rows [5] = '{12'h000, 12'h202, 12'h300, 12'h500, 12'hF00}; // addr, reset value
    always #4 clk_i = ~clk_i;
    bit_i2c #(.FILT(2), .HALF(4)) bit_i2c_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_i(scl),
        .scl_o(scl_lo), .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(sda_lo), .sda_oe_n_o(sda_oe_n));
    bus_partner bus_partner_inst (.scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n),
        .pull_scl_i(pull_scl), .pull_sda_i(pull_sda), .scl_o(scl), .sda_o(sda));
    // ----------------------------------------------------------------
    // register port cycles and comparisons
    // ----------------------------------------------------------------
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o; // data stand only in this cycle
    endtask : rd
    // bounded poll: a field that never arrives ends the run
    task wt(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        int i;
        for (i = 0; i < 200; i++) begin
            rd(a, v);
            if ((v & m) === e) break;
        end
        if (i == 200) begin
            chk(v & m, e);
            end_of_test();
        end
    endtask : wt
    // one link clock period of 80 ns, released half then pulled half
    task pulse;
        @(posedge clk_i) pull_scl <= 1'b0;
        repeat (5) @(posedge clk_i);
        pull_scl <= 1'b1;
        repeat (5) @(posedge clk_i);
    endtask : pulse
    // ----------------------------------------------------------------
    // main sequence: reset table first, then hand-written bus cases
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        foreach (rows[i]) begin
            rd(rows[i][11:8], v);
            chk(v, rows[i][7:0]);
        end
        chk({scl_lo, sda_lo, scl_oe_n, sda_oe_n}, 8'h03);
        wr(4'h5, 8'h0F);
        pull_sda <= 1'b1; // start: sda falls while scl high
        wt(4'h2, 8'h40, 8'h40);
        chk({7'h00, irq_o}, 8'h01);
        pull_scl <= 1'b1;
        wt(4'h0, 8'h01, 8'h01);
        chk({7'h00, scl_oe_n}, 8'h00);
        pull_sda <= 1'b0;
        wr(4'h1, 8'h01); // tx released, resume as slave
        rd(4'h2, v);
        chk(v & 8'hB8, 8'h00);
        pulse();
        wt(4'h2, 8'hB8, 8'hB8);
        rd(4'h1, v);
        chk(v & 8'h02, 8'h02);
        wr(4'h2, 8'h06); // resume through the control register
        pull_sda <= 1'b1; // another party wins the bit
        pulse();
        wt(4'h2, 8'hB0, 8'h90);
        rd(4'h3, v);
        chk(v & 8'h08, 8'h08);
        wr(4'h0, 8'h01);
        wr(4'h4, 8'h0F);
        repeat (2) @(posedge clk_i);
        chk({7'h00, irq_o}, 8'h00);
        wr(4'h5, 8'h00);
        wr(4'h1, 8'h01);
        @(posedge clk_i) pull_scl <= 1'b0;
        repeat (8) @(posedge clk_i);
        pull_sda <= 1'b0; // stop: sda rises while scl high
        wt(4'h2, 8'h40, 8'h00);
        rd(4'h3, v);
        chk(v & 8'h02, 8'h02);
        chk({7'h00, irq_o}, 8'h00);
        wr(4'h2, 8'h01); // master, scl held low by software
        wt(4'h2, 8'h80, 8'h80);
        wr(4'h1, 8'h00); // master bit write makes its own pulse
        repeat (3) @(posedge clk_i);
        chk({scl_oe_n, sda_oe_n}, 8'h00);
        wt(4'h2, 8'hB0, 8'hB0);
        rd(4'h1, v);
        chk(v & 8'h02, 8'h00);
        end_of_test();
    end
endmodule : tb_top
